// [rtl/aui_pkg.sv]
// package for the banked advanced uart set 0 register and interrupt block
// assumes an axi4-lite master and uart/ir datapath logic outside the block
// Behaviour
// - bank enable bit turns on eight sets
// - set select reachable everywhere, switches bank
// - sets 0,1 always; sets 2-7 enhanced only
// - set 0 offsets 0-7; offset 3 shared
// - offset 0 reads rx, writes tx
// - dma handshake only in mir/fir/remote
// - rx on, tx off: single swapped channel
// - enable bits: timer..rx threshold, one enables; bits 7:4 enhanced only
// - frame fifo enable only mir/fir
// - dma enable in mir/fir/remote
// - handshake enable needs ir handshake select
// - bit 2 line status or frame end by mode
// - timer flag at zero when enabled
// - frame fifo flag level or timeout
// - tx threshold flag while below threshold
// - dma flag on tc, clears on read
// - handshake flag on change, clears hsr read
// - line error flag, clears on status read
// - frame end flag in mir/fir
// - tx idle flag, clears on interrupt status read
// - rx threshold flag level or timeout
package aui_pkg;
  // register indices; each register takes one aligned bus word
  localparam int AUI_IDX_BUF  = 0;
  localparam int AUI_IDX_IEN  = 1;
  localparam int AUI_IDX_ISR  = 2;
  localparam int AUI_IDX_SSR  = 3;
  localparam int AUI_IDX_HCR  = 4;
  localparam int AUI_IDX_LSR  = 5;
  localparam int AUI_IDX_HSR  = 6;
  localparam int AUI_IDX_USR  = 7;
  // own configuration and bank registers after the set 0 map
  localparam int AUI_IDX_CFG  = 8;
  localparam int AUI_IDX_BANK = 9;
  // byte addresses: four times the index
  localparam logic [5:0] AUI_OFS_BUF   = 6'(4 * AUI_IDX_BUF);
  localparam logic [5:0] AUI_OFS_IEN   = 6'(4 * AUI_IDX_IEN);
  localparam logic [5:0] AUI_OFS_ISR   = 6'(4 * AUI_IDX_ISR);
  localparam logic [5:0] AUI_OFS_SSR   = 6'(4 * AUI_IDX_SSR);
  localparam logic [5:0] AUI_OFS_HCR   = 6'(4 * AUI_IDX_HCR);
  localparam logic [5:0] AUI_OFS_LSR   = 6'(4 * AUI_IDX_LSR);
  localparam logic [5:0] AUI_OFS_HSR   = 6'(4 * AUI_IDX_HSR);
  localparam logic [5:0] AUI_OFS_USR   = 6'(4 * AUI_IDX_USR);
  localparam logic [5:0] AUI_OFS_CFG   = 6'(4 * AUI_IDX_CFG);
  localparam logic [5:0] AUI_OFS_BANK  = 6'(4 * AUI_IDX_BANK);
  // config bit positions
  localparam int AUI_CFG_BNK   = 3;
  localparam int AUI_CFG_RXDMA = 0;
  localparam int AUI_CFG_TXDMA = 1;
  localparam int AUI_CFG_SWAP  = 2;
  localparam int AUI_CFG_HSSL  = 4;
  localparam int AUI_CFG_HSEN  = 5;
  localparam int AUI_CFG_TMR   = 6;
  // status bit positions
  localparam int AUI_B_TMR = 7;
  localparam int AUI_B_FSF = 6;
  localparam int AUI_B_TXT = 5;
  localparam int AUI_B_DMA = 4;
  localparam int AUI_B_HS  = 3;
  localparam int AUI_B_LS  = 2;
  localparam int AUI_B_TXE = 1;
  localparam int AUI_B_RXT = 0;
  // set select codes
  localparam logic [7:0] AUI_SEL_S2 = 8'hE0;
  localparam logic [7:0] AUI_SEL_S3 = 8'hE4;
  localparam logic [7:0] AUI_SEL_S4 = 8'hE8;
  localparam logic [7:0] AUI_SEL_S5 = 8'hEC;
  localparam logic [7:0] AUI_SEL_S6 = 8'hF0;
  localparam logic [7:0] AUI_SEL_S7 = 8'hF4;
  localparam logic [7:0] AUI_ISR_RST = 8'h22;
  localparam logic [1:0] AUI_RESP_OK  = 2'b00;
  localparam logic [1:0] AUI_RESP_ERR = 2'b10;
  // operating modes, from handshake control bits 7:5
  typedef enum logic [2:0] {
    AUI_M_UART = 3'b000, AUI_M_LMIR = 3'b001, AUI_M_ASK = 3'b010,
    AUI_M_SIR  = 3'b011, AUI_M_HMIR = 3'b100, AUI_M_FIR = 3'b101,
    AUI_M_CIR  = 3'b110, AUI_M_RSV  = 3'b111
  } aui_mode_e;
  // events from the uart/ir datapath
  typedef struct packed {
    logic       timer_zero;
    logic       fsf_at_level;
    logic       fsf_timeout;
    logic       tx_below_level;
    logic       dma_tc;
    logic       line_error;
    logic       frame_end;
    logic       tx_idle;
    logic       rx_at_level;
    logic       rx_timeout;
    logic [7:0] rx_data;
    logic [7:0] line_status;
    logic [7:0] hs_status;
  } aui_evt_s;
endpackage

// [rtl/aui_set0.sv]
// set 0 registers, bank selection and interrupt flags of the advanced uart
// assumes datapath events arrive synchronous to CLK, one per cycle each
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module aui_set0 (
  // clock and reset
  input  wire logic           CLK,
  input  wire logic           RST,
  // axi4-lite write
  input  wire logic [5:0]     S_AWADDR,
  input  wire logic           S_AWVALID,
  output logic                S_AWREADY,
  input  wire logic [31:0]    S_WDATA,
  input  wire logic [3:0]     S_WSTRB,
  input  wire logic           S_WVALID,
  output logic                S_WREADY,
  output logic [1:0]          S_BRESP,
  output logic                S_BVALID,
  input  wire logic           S_BREADY,
  // axi4-lite read
  input  wire logic [5:0]     S_ARADDR,
  input  wire logic           S_ARVALID,
  output logic                S_ARREADY,
  output logic [31:0]         S_RDATA,
  output logic [1:0]          S_RRESP,
  output logic                S_RVALID,
  input  wire logic           S_RREADY,
  // datapath
  input  wire aui_pkg::aui_evt_s EVT,
  output logic [7:0]          TX_DATA,
  output logic                TX_LOAD,
  output logic                RX_POP,
  // dma request routing
  output logic                DMA_TX_EN,
  output logic                DMA_RX_EN,
  // interrupt and bank
  output logic                IRQ,
  output logic [2:0]          BANK
);
  import aui_pkg::*;

  logic [7:0] ien, interrupt_status_reg, handshake_control, uart_line_status, cfg, ucr;
  logic [2:0] bank;
  logic [7:0] hs_prev;
  logic       aw_hold, w_hold;
  logic [5:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // bank code from a set select write value
  function automatic logic [2:0] sel_bank(input logic [7:0] v);
    case (v)
      AUI_SEL_S2: sel_bank = 3'h2;
      AUI_SEL_S3: sel_bank = 3'h3;
      AUI_SEL_S4: sel_bank = 3'h4;
      AUI_SEL_S5: sel_bank = 3'h5;
      AUI_SEL_S6: sel_bank = 3'h6;
      AUI_SEL_S7: sel_bank = 3'h7;
      default:    sel_bank = v[7] ? 3'h1 : 3'h0;
    endcase
  endfunction

  // mode decode
  wire aui_mode_e mode    = aui_mode_e'(handshake_control[7:5]);
  wire logic      enh     = cfg[AUI_CFG_BNK];
  wire logic      mirfir  = enh && (mode == AUI_M_LMIR ||
                            mode == AUI_M_HMIR || mode == AUI_M_FIR);
  wire logic      remote  = enh && mode == AUI_M_CIR;
  wire logic      fast    = mirfir || remote;
  wire logic      irmode  = enh && mode != AUI_M_UART;

  // write channel: both halves held until paired
  wire logic       wr_go  = aw_hold && w_hold && !S_BVALID;
  wire logic       set0   = bank == 3'h0;
  wire logic       wr_ok  = wr_go && w_strb[0];
  wire logic [7:0] wb     = w_data[7:0];
  wire logic       wr_buf = wr_ok && set0 && aw_addr == AUI_OFS_BUF;
  wire logic       wr_ssr = wr_ok && aw_addr == AUI_OFS_SSR;
  wire logic [2:0] nbank  = enh ? sel_bank(wb) : {2'b00, wb[7]};
  wire logic       wr_map = aw_addr <= AUI_OFS_BANK;

  // read channel decode
  wire logic       rd_go  = S_ARVALID && S_ARREADY;
  wire logic       rd_s0  = rd_go && set0;
  wire logic       rd_isr = rd_s0 && S_ARADDR == AUI_OFS_ISR;
  wire logic       rd_lsr = rd_s0 && S_ARADDR == AUI_OFS_LSR;
  wire logic       rd_hsr = rd_s0 && S_ARADDR == AUI_OFS_HSR;
  wire logic       rd_map = S_ARADDR <= AUI_OFS_BANK;
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (S_ARADDR)
      AUI_OFS_BUF:  rd_byte = set0 ? EVT.rx_data : 8'h00;
      AUI_OFS_IEN:  rd_byte = set0 ? ien : 8'h00;
      AUI_OFS_ISR:  rd_byte = set0 ? interrupt_status_reg : 8'h00;
      AUI_OFS_SSR:  rd_byte = ucr;
      AUI_OFS_HCR:  rd_byte = set0 ? handshake_control : 8'h00;
      AUI_OFS_LSR:  rd_byte = set0 ? EVT.line_status : 8'h00;
      AUI_OFS_HSR:  rd_byte = set0 ? EVT.hs_status : 8'h00;
      AUI_OFS_USR:  rd_byte = set0 ? uart_line_status : 8'h00;
      AUI_OFS_CFG:  rd_byte = cfg;
      AUI_OFS_BANK: rd_byte = {5'h00, bank};
      default:      rd_byte = 8'h00;
    endcase
  end

  // flag set terms; frame fifo, dma, handshake and bit 2 gated by mode
  wire logic hs_chg   = EVT.hs_status != hs_prev;
  wire logic hs_ok    = !irmode || cfg[AUI_CFG_HSEN];
  wire logic [7:0] set_t;
  assign set_t[AUI_B_TMR] = EVT.timer_zero && cfg[AUI_CFG_TMR] &&
                            ien[AUI_B_TMR];
  assign set_t[AUI_B_FSF] = mirfir && (EVT.fsf_at_level ||
                            EVT.fsf_timeout);
  assign set_t[AUI_B_TXT] = EVT.tx_below_level;
  assign set_t[AUI_B_DMA] = fast && EVT.dma_tc;
  assign set_t[AUI_B_HS]  = hs_chg && hs_ok;
  assign set_t[AUI_B_LS]  = mirfir ? EVT.frame_end :
                            (!remote && EVT.line_error);
  assign set_t[AUI_B_TXE] = EVT.tx_idle;
  assign set_t[AUI_B_RXT] = EVT.rx_at_level || EVT.rx_timeout;

  // clear terms; the set term wins in the same cycle
  wire logic [7:0] clr_t;
  assign clr_t[AUI_B_TMR] = rd_isr;
  assign clr_t[AUI_B_FSF] = !EVT.fsf_at_level && !EVT.fsf_timeout;
  assign clr_t[AUI_B_TXT] = !EVT.tx_below_level;
  assign clr_t[AUI_B_DMA] = rd_isr;
  assign clr_t[AUI_B_HS]  = rd_hsr;
  assign clr_t[AUI_B_LS]  = mirfir ? rd_isr : rd_lsr;
  assign clr_t[AUI_B_TXE] = rd_isr;
  assign clr_t[AUI_B_RXT] = !EVT.rx_at_level && !EVT.rx_timeout;
  wire logic [7:0] next_isr = set_t | (interrupt_status_reg & ~clr_t);

  // effective enables by mode; handshake by its select bit
  wire logic [7:0] ien_eff;
  assign ien_eff[AUI_B_TMR] = ien[AUI_B_TMR];
  assign ien_eff[AUI_B_FSF] = ien[AUI_B_FSF] && mirfir;
  assign ien_eff[AUI_B_TXT] = ien[AUI_B_TXT];
  assign ien_eff[AUI_B_DMA] = ien[AUI_B_DMA] && fast;
  assign ien_eff[AUI_B_HS]  = ien[AUI_B_HS] && cfg[AUI_CFG_HSSL];
  assign ien_eff[AUI_B_LS]  = ien[AUI_B_LS];
  assign ien_eff[AUI_B_TXE] = ien[AUI_B_TXE];
  assign ien_eff[AUI_B_RXT] = ien[AUI_B_RXT];

  // single channel when rx on and tx off; swap picks its direction
  wire logic dma_on  = fast && handshake_control[2];
  wire logic single  = cfg[AUI_CFG_RXDMA] && !cfg[AUI_CFG_TXDMA];
  wire logic next_tx = dma_on && (single ? cfg[AUI_CFG_SWAP]
                                          : cfg[AUI_CFG_TXDMA]);
  wire logic next_rx = dma_on && (single ? !cfg[AUI_CFG_SWAP]
                                          : cfg[AUI_CFG_RXDMA]);

  // axi address/data capture
  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 6'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (S_AWVALID && S_AWREADY) begin
        aw_hold <= 1'b1;
        aw_addr <= S_AWADDR;
      end else if (wr_go) begin
        aw_hold <= 1'b0;
      end
      if (S_WVALID && S_WREADY) begin
        w_hold <= 1'b1;
        w_data <= S_WDATA;
        w_strb <= S_WSTRB;
      end else if (wr_go) begin
        w_hold <= 1'b0;
      end
    end
  end

  // axi handshakes and responses
  always_ff @(posedge CLK) begin
    if (RST) begin
      S_AWREADY <= 1'b0;
      S_WREADY  <= 1'b0;
      S_BVALID  <= 1'b0;
      S_BRESP   <= AUI_RESP_OK;
      S_ARREADY <= 1'b0;
      S_RVALID  <= 1'b0;
      S_RRESP   <= AUI_RESP_OK;
      S_RDATA   <= 32'h0;
    end else begin
      S_AWREADY <= !aw_hold && !(S_AWVALID && S_AWREADY);
      S_WREADY  <= !w_hold && !(S_WVALID && S_WREADY);
      if (wr_go) begin
        S_BVALID <= 1'b1;
        S_BRESP  <= wr_map ? AUI_RESP_OK : AUI_RESP_ERR;
      end else if (S_BREADY) begin
        S_BVALID <= 1'b0;
      end
      S_ARREADY <= !S_RVALID && !rd_go;
      if (rd_go) begin
        S_RVALID <= 1'b1;
        S_RDATA  <= {24'h0, rd_byte};
        S_RRESP  <= rd_map ? AUI_RESP_OK : AUI_RESP_ERR;
      end else if (S_RREADY) begin
        S_RVALID <= 1'b0;
      end
    end
  end

  // software registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      ien  <= 8'h00;
      handshake_control  <= 8'h00;
      uart_line_status  <= 8'h00;
      cfg  <= 8'h00;
      ucr  <= 8'h00;
      bank <= 3'h0;
    end else begin
      if (wr_ok && set0 && aw_addr == AUI_OFS_IEN)
        ien <= enh ? wb : {4'h0, wb[3:0]};
      if (wr_ok && set0 && aw_addr == AUI_OFS_HCR)
        handshake_control <= wb;
      if (wr_ok && set0 && aw_addr == AUI_OFS_USR)
        uart_line_status <= wb;
      if (wr_ok && aw_addr == AUI_OFS_CFG)
        cfg <= wb;
      if (wr_ssr) begin
        bank <= nbank;
        if (bank <= 3'h1)
          ucr <= wb;
      end
      if (!enh && bank > 3'h1)
        bank <= 3'h0;
    end
  end

  // flags, datapath strobes and outputs
  always_ff @(posedge CLK) begin
    if (RST) begin
      interrupt_status_reg       <= AUI_ISR_RST;
      hs_prev   <= 8'h00;
      TX_DATA   <= 8'h00;
      TX_LOAD   <= 1'b0;
      RX_POP    <= 1'b0;
      DMA_TX_EN <= 1'b0;
      DMA_RX_EN <= 1'b0;
      IRQ       <= 1'b0;
      BANK      <= 3'h0;
    end else begin
      interrupt_status_reg       <= next_isr;
      hs_prev   <= EVT.hs_status;
      TX_LOAD   <= wr_buf;
      if (wr_buf)
        TX_DATA <= wb;
      RX_POP    <= rd_s0 && S_ARADDR == AUI_OFS_BUF;
      DMA_TX_EN <= next_tx;
      DMA_RX_EN <= next_rx;
      IRQ       <= |(next_isr & ien_eff);
      BANK      <= bank;
    end
  end

  // assertions
  property p_irq;
    @(posedge CLK) disable iff (RST)
      1'b1 |=> IRQ == |($past(next_isr) & $past(ien_eff));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_dma_clr;
    @(posedge CLK) disable iff (RST)
      rd_isr && !set_t[AUI_B_DMA] |=> !interrupt_status_reg[AUI_B_DMA];
  endproperty
  a_dma_clr: assert property (p_dma_clr) else $error("dma flag kept");

  property p_dma_set;
    @(posedge CLK) disable iff (RST)
      fast && EVT.dma_tc |=> interrupt_status_reg[AUI_B_DMA];
  endproperty
  a_dma_set: assert property (p_dma_set) else $error("dma flag lost");

  property p_hs_clr;
    @(posedge CLK) disable iff (RST)
      rd_hsr && !set_t[AUI_B_HS] |=> !interrupt_status_reg[AUI_B_HS];
  endproperty
  a_hs_clr: assert property (p_hs_clr) else $error("hs flag kept");

  property p_txt;
    @(posedge CLK) disable iff (RST)
      1'b1 |=> interrupt_status_reg[AUI_B_TXT] == $past(EVT.tx_below_level);
  endproperty
  a_txt: assert property (p_txt) else $error("tx threshold wrong");

  property p_txe;
    @(posedge CLK) disable iff (RST)
      EVT.tx_idle |=> interrupt_status_reg[AUI_B_TXE];
  endproperty
  a_txe: assert property (p_txe) else $error("tx idle lost");

  property p_fsf;
    @(posedge CLK) disable iff (RST)
      !mirfir |=> !interrupt_status_reg[AUI_B_FSF] || $past(interrupt_status_reg[AUI_B_FSF]);
  endproperty
  a_fsf: assert property (p_fsf) else $error("fsf set off mode");

  property p_tmr;
    @(posedge CLK) disable iff (RST)
      EVT.timer_zero && !cfg[AUI_CFG_TMR] && rd_isr |=> !interrupt_status_reg[AUI_B_TMR];
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer flag ungated");

  sequence s_sel;
    wr_ssr && enh && wb == AUI_SEL_S7;
  endsequence
  property p_bank;
    @(posedge CLK) disable iff (RST)
      s_sel |=> bank == 3'h7 ##1 BANK == 3'h7;
  endproperty
  a_bank: assert property (p_bank) else $error("bank not switched");

  property p_single;
    @(posedge CLK) disable iff (RST)
      dma_on && single |=> DMA_TX_EN != DMA_RX_EN;
  endproperty
  a_single: assert property (p_single) else $error("single dma bad");

  // flag set terms, rx threshold clear, buffer strobe and legacy bank limit
  property p_tmr_set;
    @(posedge CLK) disable iff (RST)
      EVT.timer_zero && cfg[AUI_CFG_TMR] && ien[AUI_B_TMR]
        |=> interrupt_status_reg[AUI_B_TMR];
  endproperty
  a_tmr_set: assert property (p_tmr_set) else $error("timer lost");

  property p_rxt_set;
    @(posedge CLK) disable iff (RST)
      EVT.rx_at_level || EVT.rx_timeout |=> interrupt_status_reg[AUI_B_RXT];
  endproperty
  a_rxt_set: assert property (p_rxt_set) else $error("rx level lost");

  property p_rxt_clr;
    @(posedge CLK) disable iff (RST)
      !EVT.rx_at_level && !EVT.rx_timeout |=> !interrupt_status_reg[AUI_B_RXT];
  endproperty
  a_rxt_clr: assert property (p_rxt_clr) else $error("rx level kept");

  property p_ls_err;
    @(posedge CLK) disable iff (RST)
      !mirfir && !remote && EVT.line_error |=> interrupt_status_reg[AUI_B_LS];
  endproperty
  a_ls_err: assert property (p_ls_err) else $error("line error lost");

  property p_fend;
    @(posedge CLK) disable iff (RST)
      mirfir && EVT.frame_end |=> interrupt_status_reg[AUI_B_LS];
  endproperty
  a_fend: assert property (p_fend) else $error("frame end lost");

  property p_hs_set;
    @(posedge CLK) disable iff (RST)
      hs_chg && hs_ok |=> interrupt_status_reg[AUI_B_HS];
  endproperty
  a_hs_set: assert property (p_hs_set) else $error("hs change lost");

  property p_legacy;
    @(posedge CLK) disable iff (RST)
      !enh |=> bank <= 3'h1;
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy bank high");

  property p_tx_load;
    @(posedge CLK) disable iff (RST)
      wr_buf |=> TX_LOAD && TX_DATA == $past(wb);
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("tx load wrong");
endmodule

// [testbench/aui_host.sv]
// axi4-lite master model standing in for the host processor
// assumes the set 0 slave, one write and one read under way at most
`timescale 1ns/1ps
module aui_host (
  // clock
  input  wire logic        CLK,
  // write channels
  output logic [5:0]       S_AWADDR,
  output logic             S_AWVALID,
  input  wire logic        S_AWREADY,
  output logic [31:0]      S_WDATA,
  output logic [3:0]       S_WSTRB,
  output logic             S_WVALID,
  input  wire logic        S_WREADY,
  input  wire logic [1:0]  S_BRESP,
  input  wire logic        S_BVALID,
  output logic             S_BREADY,
  // read channels
  output logic [5:0]       S_ARADDR,
  output logic             S_ARVALID,
  input  wire logic        S_ARREADY,
  input  wire logic [31:0] S_RDATA,
  input  wire logic [1:0]  S_RRESP,
  input  wire logic        S_RVALID,
  output logic             S_RREADY,
  // a wait ran out
  output logic             HUNG
);
  // idle bus from time zero
  initial begin
    {S_AWADDR, S_AWVALID, S_WDATA, S_WSTRB, S_WVALID, S_BREADY} = '0;
    {S_ARADDR, S_ARVALID, S_RREADY, HUNG} = '0;
  end
  // write: both halves offered, each dropped at the edge it is taken
  task automatic wr(input logic [5:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge CLK);
    S_AWADDR <= a;
    S_WDATA <= {24'h000000, d};
    S_WSTRB <= 4'hF;
    S_AWVALID <= 1'b1;
    S_WVALID <= 1'b1;
    S_BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (S_AWREADY) S_AWVALID <= 1'b0;
      if (S_WREADY) S_WVALID <= 1'b0;
    end while (!S_BVALID && n < 64);
    r = S_BRESP;
    S_BREADY <= 1'b0;
    if (n >= 64) HUNG <= 1'b1;
  endtask
  // read: address held until taken, data taken with rvalid
  task automatic rd(input logic [5:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge CLK);
    S_ARADDR <= a;
    S_ARVALID <= 1'b1;
    S_RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (S_ARREADY) S_ARVALID <= 1'b0;
    end while (!S_RVALID && n < 64);
    d = S_RDATA;
    r = S_RRESP;
    S_RREADY <= 1'b0;
    if (n >= 64) HUNG <= 1'b1;
  endtask
endmodule

// [testbench/aui_set0_test.sv]
// self-checking bench for the set 0 register and interrupt block
// assumes aui_host as bus master; the bench plays the uart/ir datapath
`timescale 1ns/1ps
module advanced_uart_ir_set0_interrupts_test;
  import aui_pkg::*;
  logic              CLK = 1'b0;
  logic              RST = 1'b1;
  aui_evt_s          EVT = '0;
  logic [5:0]        S_AWADDR, S_ARADDR;
  logic [31:0]       S_WDATA, S_RDATA, rv;
  logic [3:0]        S_WSTRB;
  logic [1:0]        S_BRESP, S_RRESP, rs;
  logic              S_AWVALID, S_AWREADY, S_WVALID, S_WREADY, S_BVALID;
  logic              S_BREADY, S_ARVALID, S_ARREADY, S_RVALID, S_RREADY;
  logic [7:0]        TX_DATA;
  logic              TX_LOAD, RX_POP, DMA_TX_EN, DMA_RX_EN, IRQ, HUNG;
  logic [2:0]        BANK;
  int                failures = 0;
  int                n_compared = 0;
  int                n_load = 0;
  int                n_pop = 0;
  typedef struct packed {
    logic [5:0] a;
    logic [7:0] d;
    logic [7:0] q;
    logic [1:0] s;
  } aui_row_s;
  // address, write value, read back, response
  localparam aui_row_s ROWS [6] = '{
    '{6'h1C, 8'hA5, 8'hA5, 2'b00},
    '{6'h04, 8'hFF, 8'h0F, 2'b00},
    '{6'h20, 8'h08, 8'h08, 2'b00},
    '{6'h04, 8'hFF, 8'hFF, 2'b00},
    '{6'h28, 8'h55, 8'h00, 2'b10},
    '{6'h10, 8'hA0, 8'hA0, 2'b00}
  };
  // event bit positions in the struct and the status they raise
  localparam int EV_K [10] = '{33, 32, 31, 30, 29, 27, 26, 25, 24, 0};
  localparam logic [7:0] EV_Q [10] = '{8'h80, 8'h40, 8'h40, 8'h20,
    8'h10, 8'h04, 8'h02, 8'h01, 8'h01, 8'h08};
  // clock at 50 MHz
  always #10 CLK = ~CLK;
  aui_set0 dut (.CLK, .RST, .S_AWADDR, .S_AWVALID, .S_AWREADY, .S_WDATA,
    .S_WSTRB, .S_WVALID, .S_WREADY, .S_BRESP, .S_BVALID, .S_BREADY,
    .S_ARADDR, .S_ARVALID, .S_ARREADY, .S_RDATA, .S_RRESP, .S_RVALID,
    .S_RREADY, .EVT, .TX_DATA, .TX_LOAD, .RX_POP, .DMA_TX_EN,
    .DMA_RX_EN, .IRQ, .BANK);
  aui_host host (.CLK, .S_AWADDR, .S_AWVALID, .S_AWREADY, .S_WDATA,
    .S_WSTRB, .S_WVALID, .S_WREADY, .S_BRESP, .S_BVALID, .S_BREADY,
    .S_ARADDR, .S_ARVALID, .S_ARREADY, .S_RDATA, .S_RRESP, .S_RVALID,
    .S_RREADY, .HUNG);
  // count the one-cycle buffer strobes
  always @(posedge CLK) begin
    if (TX_LOAD === 1'b1) n_load++;
    if (RX_POP === 1'b1) n_pop++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // bus access plus one edge so registered outputs and counts settle
  task automatic w(input logic [5:0] a, input logic [7:0] d);
    host.wr(a, d, rs);
    @(posedge CLK);
  endtask
  task automatic r(input logic [5:0] a);
    host.rd(a, rv, rs);
    @(posedge CLK);
  endtask
  // hold one event, expect no interrupt output
  task automatic quiet(input logic [33:0] m);
    @(posedge CLK);
    EVT <= aui_evt_s'(m);
    repeat (3) @(posedge CLK);
    check(IRQ, 32'h0);
    EVT <= '0;
  endtask
  // a bus wait that ran out ends the run
  always @(posedge HUNG) begin
    failures++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    EVT.tx_below_level = 1'b1;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    check({IRQ, BANK, DMA_TX_EN, DMA_RX_EN}, 32'h0);
    r(AUI_OFS_ISR);
    check(rv, {24'h0, AUI_ISR_RST});
    EVT.tx_below_level <= 1'b0;
    r(AUI_OFS_ISR);
    check(rv, 32'h0);
    // legacy select: bit 7 reaches set 1 only
    w(AUI_OFS_SSR, 8'h80);
    check(BANK, 32'h1);
    w(AUI_OFS_SSR, AUI_SEL_S2);
    check(BANK, 32'h1);
    w(AUI_OFS_SSR, 8'h00);
    check(BANK, 32'h0);
    foreach (ROWS[i]) begin
      w(ROWS[i].a, ROWS[i].d);
      check(rs, ROWS[i].s);
      r(ROWS[i].a);
      check(rs, ROWS[i].s);
      check(rv, {24'h0, ROWS[i].q});
    end
    // enhanced sets and the shared select offset
    w(AUI_OFS_SSR, AUI_SEL_S2);
    check(BANK, 32'h2);
    r(AUI_OFS_USR);
    check(rv, 32'h0);
    w(AUI_OFS_SSR, AUI_SEL_S7);
    check(BANK, 32'h7);
    w(AUI_OFS_SSR, 8'h00);
    check(BANK, 32'h0);
    // buffer offset
    EVT.rx_data <= 8'h3C;
    w(AUI_OFS_BUF, 8'h5A);
    check({TX_DATA, n_load[7:0]}, 32'h5A01);
    r(AUI_OFS_BUF);
    check({rv[7:0], n_pop[7:0]}, 32'h3C01);
    // dma channel routing
    w(AUI_OFS_HCR, 8'hA4);
    w(AUI_OFS_CFG, 8'h0D);
    check({DMA_TX_EN, DMA_RX_EN}, 32'h2);
    w(AUI_OFS_CFG, 8'h09);
    check({DMA_TX_EN, DMA_RX_EN}, 32'h1);
    w(AUI_OFS_HCR, 8'h04);
    check({DMA_TX_EN, DMA_RX_EN}, 32'h0);
    // every flag source in fast infrared mode
    w(AUI_OFS_HCR, 8'hA0);
    w(AUI_OFS_CFG, 8'h78);
    EVT <= '0;
    foreach (EV_K[i]) begin
      @(posedge CLK);
      EVT <= aui_evt_s'(34'h1 << EV_K[i]);
      repeat (3) @(posedge CLK);
      check(IRQ, 32'h1);
      r(AUI_OFS_ISR);
      check(rv, {24'h0, EV_Q[i]});
      EVT <= '0;
      repeat (2) @(posedge CLK);
      r(AUI_OFS_ISR);
      r(AUI_OFS_LSR);
      r(AUI_OFS_HSR);
      r(AUI_OFS_ISR);
      check(rv, 32'h0);
      check(IRQ, 32'h0);
    end
    // masked and mode-gated sources
    w(AUI_OFS_IEN, 8'hEF);
    quiet(34'h020000000);
    r(AUI_OFS_ISR);
    check(rv, 32'h10);
    w(AUI_OFS_IEN, 8'hFF);
    w(AUI_OFS_CFG, 8'h68);
    quiet(34'h000000001);
    w(AUI_OFS_HCR, 8'h40);
    quiet(34'h100000000);
    // line error in amplitude-keyed mode, cleared by a status read
    @(posedge CLK);
    EVT <= aui_evt_s'(34'h010000000);
    repeat (3) @(posedge CLK);
    check(IRQ, 32'h1);
    EVT <= '0;
    r(AUI_OFS_ISR);
    check(rv & 32'h04, 32'h04);
    r(AUI_OFS_LSR);
    r(AUI_OFS_ISR);
    check(rv & 32'h04, 32'h0);
    // timer zero with the timer stopped raises nothing
    w(AUI_OFS_CFG, 8'h28);
    EVT <= aui_evt_s'(34'h200000000);
    r(AUI_OFS_ISR);
    check(rv & 32'h80, 32'h0);
    check(IRQ, 32'h0);
    EVT <= '0;
    // reset in mid-run
    RST <= 1'b1;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    repeat (2) @(posedge CLK);
    check({IRQ, BANK, DMA_TX_EN, DMA_RX_EN}, 32'h0);
    r(AUI_OFS_IEN);
    check(rv, 32'h0);
    tally_and_finish();
  end
endmodule
